// file: verilog/pps_core.sv
// Supervisory and conditioning logic around the process control loop.
`timescale 1ns/1ns
// How it works
// - Loop runs only when mode bit 0 is set; else plain frequency command.
// - Mode bit 1 reverses polarity so output falls as target rises.
// - Feedback is multiplied by a programmable feedback gain before comparison.
// - Integral contribution is clamped to a programmable limit.
// - Loop output is clamped to a percent limit, 100% is maximum frequency.
// - A first-order low-pass stage follows the output limit.
// - Signed bias times output gain is added to the frequency reference.
// - Negative output reverses direction if allowed, else is held at zero.
// - Target changes are ramped; a function-36 input bypasses the ramp.
// - Loss selector: 0 off, 1 warning, 2 fault.
// - Loss declared when feedback stays below a level for a set time.
// - Warning mode shows the warning indication and keeps running.
// - Fault mode shows fault indication, stops the drive, asserts fault contact.
// - During loss warning a forced frequency is driven; control resumes after.
// - Output below sleep frequency for the sleep delay enters sleep at zero.
// - Reference above wake frequency for wake delay restarts and ramps up.
// - Sleep selector: 0 off, 1 timed, 2 digital input controlled.
// - Without compensation, timer expiry decelerates to stop and sleeps.
// - With compensation, expiry moves gradually to sleep frequency, fixed command only.
// - Loop keeps evaluating while asleep to check the wake condition.
// - Same target and feedback source is rejected with a setting-error alarm.
// - Displayed feedback is scaled by a display bias and display gain.
// - Target is clamped between programmable upper and lower limits.
// - Gain-set selector: set 1, set 2, set 2 on input, set 2 on clock event.
// - Set 1 uses primary target, proportional gain, integral and differential time.
// - In input mode a function-54 input switches to gain set 2.
module pps_core
    import pps_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic [3:0]              ctrl_mode,
    input  wire logic [1:0]              target_src,
    input  wire logic [1:0]              feedback_src,
    input  wire logic [PCT_W-1:0]        ain1_pct,
    input  wire logic [PCT_W-1:0]        ain2_pct,
    input  wire logic [PCT_W-1:0]        target_setting,
    input  wire logic [PCT_W-1:0]        target_upper,
    input  wire logic [PCT_W-1:0]        target_lower,
    input  wire logic [PCT_W-1:0]        feedback_gain,
    input  wire logic [PCT_W-1:0]        integral_limit,
    input  wire logic [PCT_W-1:0]        output_limit,
    input  wire logic [7:0]              filter_shift,
    input  wire logic signed [PCT_W-1:0] bias_pct,
    input  wire logic [PCT_W-1:0]        output_gain,
    input  wire logic                    reverse_allow,
    input  wire logic [TIME_W-1:0]       target_ramp_time,
    input  wire logic [8*DI_COUNT-1:0]   di_function,
    input  wire logic [DI_COUNT-1:0]     di_pin,
    input  wire logic [1:0]              loss_sel,
    input  wire logic [PCT_W-1:0]        loss_level,
    input  wire logic [TIME_W-1:0]       loss_time,
    input  wire logic [FREQ_W-1:0]       forced_freq,
    input  wire logic [1:0]              sleep_sel,
    input  wire logic                    sleep_di,
    input  wire logic                    sleep_comp,
    input  wire logic                    fixed_freq_cmd,
    input  wire logic [FREQ_W-1:0]       sleep_freq,
    input  wire logic [TIME_W-1:0]       sleep_time,
    input  wire logic [FREQ_W-1:0]       wake_freq,
    input  wire logic [TIME_W-1:0]       wake_time,
    input  wire logic [FREQ_W-1:0]       freq_cmd,
    input  wire logic [FREQ_W-1:0]       max_freq,
    input  wire logic signed [PCT_W-1:0] disp_bias,
    input  wire logic [PCT_W-1:0]        disp_gain,
    input  wire logic [1:0]              gain_sel,
    input  wire logic                    rtc_event,
    input  wire logic [PCT_W-1:0]        loop_out_pct,
    input  wire logic [PCT_W-1:0]        loop_integral_pct,
    input  wire logic                    loop_negative,
    output logic [PCT_W-1:0]             loop_target,
    output logic [PCT_W-1:0]             loop_feedback,
    output logic                         loop_enable,
    output logic                         loop_reverse,
    output logic                         gain_set_secondary,
    output logic [FREQ_W-1:0]            freq_ref,
    output logic                         dir_reverse,
    output logic                         drive_stop,
    output logic                         fault_contact,
    output logic                         loss_warning_indication,
    output logic                         loss_fault_indication,
    output logic                         setting_error_alarm,
    output logic                         sleep_active,
    output logic signed [PCT_W-1:0]      feedback_display
);
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [PCT_W-1:0] scale_pct(input logic [PCT_W-1:0] a,
                                                   input logic [PCT_W-1:0] g);
        logic [2*PCT_W-1:0] p;
        p = (a * g) / PCT_FULL;
        scale_pct = (p > {{PCT_W{1'b0}}, 16'hffff}) ? 16'hffff : p[PCT_W-1:0];
    endfunction

    function automatic logic [PCT_W-1:0] clamp(input logic [PCT_W-1:0] v,
                                               input logic [PCT_W-1:0] lo,
                                               input logic [PCT_W-1:0] hi);
        clamp = (v > hi) ? hi : (v < lo) ? lo : v;
    endfunction

    // ************************************************************
    // Input synchronisers and tick
    // ************************************************************
    logic [DI_COUNT+2:0] sync1_r;
    logic [DI_COUNT+2:0] sync2_r;
    logic [23:0]         tick_cnt_r;
    logic [15:0]         filt_cnt_r;
    wire                 tick     = (tick_cnt_r == 24'(TICK_CYCLES - 1));
    wire                 filt_stp = (filt_cnt_r == 16'(FILT_STEP_CYC - 1));
    wire [DI_COUNT-1:0]  di_s     = sync2_r[DI_COUNT-1:0];
    wire                 slp_di_s = sync2_r[DI_COUNT];
    wire                 rtc_s    = sync2_r[DI_COUNT+1];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_r    <= '0;
            sync2_r    <= '0;
            tick_cnt_r <= '0;
            filt_cnt_r <= '0;
        end else begin
            sync1_r    <= {1'b0, rtc_event, sleep_di, di_pin};
            sync2_r    <= sync1_r;
            tick_cnt_r <= tick ? 24'h00_0000 : tick_cnt_r + 24'h00_0001;
            filt_cnt_r <= filt_stp ? 16'h0000 : filt_cnt_r + 16'h0001;
        end
    end

    logic ramp_off;
    logic di_set2;
    always_comb begin
        ramp_off = 1'b0;
        di_set2  = 1'b0;
        for (int i = 0; i < DI_COUNT; i++) begin
            if (di_s[i] && di_function[8*i +: 8] == DI_FN_RAMP_OFF) ramp_off = 1'b1;
            if (di_s[i] && di_function[8*i +: 8] == DI_FN_SET2) di_set2 = 1'b1;
        end
    end

    // ************************************************************
    // Target and feedback selection
    // ************************************************************
    wire [PCT_W-1:0] tgt_raw = (target_src == 2'h1) ? ain1_pct :
                               (target_src == 2'h2) ? ain2_pct : target_setting;
    wire [PCT_W-1:0] fb_raw  = (feedback_src == 2'h2) ? ain2_pct : ain1_pct;
    wire [PCT_W-1:0] tgt_lim = clamp(tgt_raw, target_lower, target_upper);
    wire [PCT_W-1:0] fb_gain = scale_pct(fb_raw, feedback_gain);

    assign setting_error_alarm = (target_src == feedback_src);
    assign loop_enable  = ctrl_mode[MODE_EN_BIT] && !setting_error_alarm;
    assign loop_reverse = ctrl_mode[MODE_REV_BIT];
    assign gain_set_secondary = (gain_sel == GSEL_SEC) ||
                                (gain_sel == GSEL_DI && di_set2) ||
                                (gain_sel == GSEL_RTC && rtc_s);

    // ************************************************************
    // Target ramp, output conditioning and filter
    // ************************************************************
    logic [PCT_W-1:0] ramp_r;
    logic [PCT_W-1:0] filt_r;
    wire  [PCT_W-1:0] ramp_step = (target_ramp_time == RST_TIME) ? PCT_FULL :
                                  PCT_W'(PCT_FULL / target_ramp_time);
    wire  [PCT_W:0]   ramp_up   = {1'b0, ramp_r} + {1'b0, ramp_step};
    wire  [PCT_W-1:0] ramp_nxt  = (ramp_off || ramp_step == PCT_FULL) ? tgt_lim :
                        !tick ? ramp_r :
                        (tgt_lim > ramp_r) ? ((ramp_up > {1'b0, tgt_lim}) ? tgt_lim :
                                              ramp_up[PCT_W-1:0]) :
                        ((ramp_r - tgt_lim) > ramp_step) ? ramp_r - ramp_step : tgt_lim;
    assign loop_target   = ramp_r;
    assign loop_feedback = fb_gain;

    wire [PCT_W-1:0] integ_ok = (loop_integral_pct > integral_limit) ? integral_limit :
                                loop_integral_pct;
    wire [PCT_W-1:0] prop_part = loop_out_pct - loop_integral_pct;
    wire [PCT_W:0]   sum_raw   = {1'b0, prop_part} + {1'b0, integ_ok};
    wire [PCT_W-1:0] out_lim   = (sum_raw > {1'b0, output_limit}) ? output_limit :
                                 sum_raw[PCT_W-1:0];
    wire [PCT_W-1:0] filt_diff = (out_lim > filt_r) ? out_lim - filt_r : filt_r - out_lim;
    wire [PCT_W-1:0] filt_d    = (filt_diff >> filter_shift) | {15'h0000, |filt_diff};
    wire [PCT_W-1:0] filt_nxt  = !filt_stp ? filt_r :
                                 (out_lim > filt_r) ? filt_r + filt_d : filt_r - filt_d;
    wire             neg_hold  = loop_negative && !reverse_allow;
    wire [PCT_W-1:0] loop_mag  = neg_hold ? RST_PCT : filt_r;
    wire [PCT_W-1:0] bias_mag  = bias_pct[PCT_W-1] ? PCT_W'(-bias_pct) : bias_pct;
    wire [PCT_W-1:0] bias_amt  = scale_pct(bias_mag, output_gain);
    wire [PCT_W:0]   bias_sum  = bias_pct[PCT_W-1] ?
                                 ((loop_mag > bias_amt) ? {1'b0, loop_mag - bias_amt} : '0) :
                                 {1'b0, loop_mag} + {1'b0, bias_amt};
    wire [PCT_W-1:0] ref_pct   = bias_sum[PCT_W] ? 16'hffff : bias_sum[PCT_W-1:0];
    wire [FREQ_W-1:0] ref_freq = loop_enable ? scale_pct(ref_pct, max_freq) : freq_cmd;

    // ************************************************************
    // Feedback loss, sleep and wake supervision
    // ************************************************************
    pps_state_e      st_r;
    pps_state_e      st_nxt;
    logic [FREQ_W-1:0] out_r;
    logic            loss_done;
    logic            sleep_done;
    logic            wake_done;
    logic            warn_r;
    logic            fault_r;
    wire  loss_cond  = loop_enable && loss_sel != LOSS_OFF && fb_gain < loss_level;
    wire  slp_cond   = loop_enable && sleep_sel == SLP_TIMED && out_r < sleep_freq;
    wire  wake_cond  = ref_freq > wake_freq;
    wire  ramp_dn    = (out_r > sleep_freq) ? 1'b1 : 1'b0;

    pps_timer u_loss  (.core_clk(core_clk), .rst(rst), .tick(tick), .cond(loss_cond),
                       .limit(loss_time), .done(loss_done));
    pps_timer u_sleep (.core_clk(core_clk), .rst(rst), .tick(tick),
                       .cond(slp_cond && st_r == PPS_RUN),
                       .limit(sleep_time), .done(sleep_done));
    pps_timer u_wake  (.core_clk(core_clk), .rst(rst), .tick(tick),
                       .cond(wake_cond && st_r == PPS_SLEEP),
                       .limit(wake_time), .done(wake_done));

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            PPS_RUN: begin
                if (sleep_sel == SLP_DI && slp_di_s) st_nxt = PPS_SLEEP;
                else if (sleep_done && sleep_comp && fixed_freq_cmd) st_nxt = PPS_COMP;
                else if (sleep_done) st_nxt = PPS_SLEEP_DEC;
            end
            PPS_SLEEP_DEC: st_nxt = PPS_SLEEP;
            PPS_SLEEP: begin
                if (sleep_sel == SLP_OFF) st_nxt = PPS_RUN;
                else if (sleep_sel == SLP_DI) st_nxt = slp_di_s ? PPS_SLEEP : PPS_RUN;
                else if (wake_done) st_nxt = PPS_RUN;
            end
            PPS_COMP: if (!slp_cond) st_nxt = PPS_RUN;
            default: st_nxt = PPS_RUN;
        endcase
    end

    wire [FREQ_W-1:0] out_nxt =
        (fault_r || st_r == PPS_SLEEP || st_r == PPS_SLEEP_DEC) ? RST_FREQ :
        warn_r ? forced_freq :
        (st_r == PPS_COMP) ? (ramp_dn ? out_r - 16'h0001 : sleep_freq) :
        ref_freq;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r    <= PPS_RUN;
            ramp_r  <= RST_PCT;
            filt_r  <= RST_PCT;
            out_r   <= RST_FREQ;
            warn_r  <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            ramp_r  <= ramp_nxt;
            filt_r  <= filt_nxt;
            out_r   <= out_nxt;
            warn_r  <= loss_done && loss_sel == LOSS_WARN;
            fault_r <= fault_r || (loss_done && loss_sel == LOSS_FAULT);
        end
    end

    // ************************************************************
    // Outputs and feedback display
    // ************************************************************
    logic signed [PCT_W-1:0] disp_r;
    wire signed [31:0] disp_calc = 32'(signed'({1'b0, scale_pct(fb_raw, disp_gain)})) +
                                   32'(disp_bias);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            disp_r <= '0;
        end else begin
            disp_r <= disp_calc[PCT_W-1:0];
        end
    end

    assign freq_ref                = out_r;
    assign dir_reverse             = loop_enable && loop_negative && reverse_allow;
    assign drive_stop              = fault_r || st_r == PPS_SLEEP;
    assign fault_contact           = fault_r;
    assign loss_warning_indication = warn_r;
    assign loss_fault_indication   = fault_r;
    assign sleep_active            = (st_r == PPS_SLEEP || st_r == PPS_SLEEP_DEC);
    assign feedback_display        = disp_r;
endmodule

// file: verilog/pps_pkg.sv
// Constants, field layouts and encodings shared by the process supervisor.
package pps_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned TICK_SEC_TENTH = 1;
    localparam int unsigned TICK_CYCLES    = CLK_HZ / 10 * TICK_SEC_TENTH;
    localparam int unsigned FILT_STEP_CYC  = 20_000;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int unsigned PCT_W  = 16;
    localparam int unsigned FREQ_W = 16;
    localparam int unsigned TIME_W = 12;

    // ************************************************************
    // Control mode field bits
    // ************************************************************
    localparam int unsigned MODE_EN_BIT  = 0;
    localparam int unsigned MODE_REV_BIT = 1;

    // ************************************************************
    // Selector encodings
    // ************************************************************
    localparam logic [1:0] LOSS_OFF   = 2'h0;
    localparam logic [1:0] LOSS_WARN  = 2'h1;
    localparam logic [1:0] LOSS_FAULT = 2'h2;
    localparam logic [1:0] SLP_OFF    = 2'h0;
    localparam logic [1:0] SLP_TIMED  = 2'h1;
    localparam logic [1:0] SLP_DI     = 2'h2;
    localparam logic [1:0] GSEL_PRI   = 2'h0;
    localparam logic [1:0] GSEL_SEC   = 2'h1;
    localparam logic [1:0] GSEL_DI    = 2'h2;
    localparam logic [1:0] GSEL_RTC   = 2'h3;

    // ************************************************************
    // Digital input function codes and scale factors
    // ************************************************************
    localparam logic [7:0] DI_FN_RAMP_OFF = 8'h24;
    localparam logic [7:0] DI_FN_SET2     = 8'h36;
    localparam int unsigned DI_COUNT      = 6;
    localparam logic [PCT_W-1:0] PCT_FULL = 16'h2710;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [PCT_W-1:0]  RST_PCT  = 16'h0000;
    localparam logic [FREQ_W-1:0] RST_FREQ = 16'h0000;
    localparam logic [TIME_W-1:0] RST_TIME = 12'h000;

    typedef enum logic [1:0] {
        PPS_RUN,
        PPS_SLEEP_DEC,
        PPS_SLEEP,
        PPS_COMP
    } pps_state_e;

endpackage

// file: verilog/pps_timer.sv
// Qualified-condition timer counting tenths of a second.
`timescale 1ns/1ns
module pps_timer
    import pps_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              tick,
    input  wire logic              cond,
    input  wire logic [TIME_W-1:0] limit,
    output logic                   done
);
    logic [TIME_W-1:0] cnt_r;
    logic [TIME_W-1:0] cnt_nxt;
    wire               at_limit = (cnt_r >= limit);

    assign cnt_nxt = !cond ? RST_TIME :
                     (tick && !at_limit) ? cnt_r + TIME_W'(1) : cnt_r;
    assign done = cond && at_limit;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= RST_TIME;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// file: sim/pps_plant.sv
// Behavioural feedback transducer and loop output stage for the supervisor.
`timescale 1ns/1ns
module pps_plant
    import pps_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [PCT_W-1:0] sp,
    input  wire logic [PCT_W-1:0] press,
    input  wire logic [PCT_W-1:0] demand,
    input  wire logic             neg,
    output logic [PCT_W-1:0]      ain1_pct,
    output logic [PCT_W-1:0]      ain2_pct,
    output logic [PCT_W-1:0]      loop_out_pct,
    output logic [PCT_W-1:0]      loop_integral_pct,
    output logic                  loop_negative
);
    // The transducers and the loop stage answer one cycle after the bench sets them.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ain1_pct <= RST_PCT;
            ain2_pct <= RST_PCT;
            loop_out_pct <= RST_PCT;
            loop_integral_pct <= RST_PCT;
            loop_negative <= 1'b0;
        end else begin
            ain1_pct <= sp;
            ain2_pct <= press;
            loop_out_pct <= demand;
            loop_integral_pct <= demand >> 1;
            loop_negative <= neg;
        end
    end
endmodule

// file: sim/pps_core_props.sv
// Concurrent checks on the ports of the process supervisor.
`timescale 1ns/1ns
module pps_core_props
    import pps_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic [3:0]        ctrl_mode,
    input wire logic [1:0]        target_src,
    input wire logic [1:0]        feedback_src,
    input wire logic [1:0]        gain_sel,
    input wire logic              reverse_allow,
    input wire logic [1:0]        loss_sel,
    input wire logic [FREQ_W-1:0] forced_freq,
    input wire logic              loop_enable,
    input wire logic              loop_reverse,
    input wire logic              gain_set_secondary,
    input wire logic [FREQ_W-1:0] freq_ref,
    input wire logic              dir_reverse,
    input wire logic              drive_stop,
    input wire logic              fault_contact,
    input wire logic              loss_warning_indication,
    input wire logic              loss_fault_indication,
    input wire logic              setting_error_alarm,
    input wire logic              sleep_active
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    same_src_alarm_a: assert property (feedback_src != 2'h0 && target_src == feedback_src
        |-> setting_error_alarm) else $error("same source without alarm");
    alarm_stops_loop_a: assert property (setting_error_alarm |-> !loop_enable)
        else $error("loop runs with setting alarm");
    loop_gate_a: assert property (!ctrl_mode[MODE_EN_BIT] |-> !loop_enable)
        else $error("loop runs with mode bit clear");
    polarity_sel_a: assert property (loop_enable |-> loop_reverse == ctrl_mode[MODE_REV_BIT])
        else $error("polarity does not follow mode");
    gain_pri_a: assert property (gain_sel == GSEL_PRI |-> !gain_set_secondary)
        else $error("secondary set in primary mode");
    gain_sec_a: assert property (gain_sel == GSEL_SEC |-> gain_set_secondary)
        else $error("primary set in secondary mode");
    dir_permit_a: assert property (dir_reverse |-> reverse_allow)
        else $error("reverse without permission");
    fault_outputs_a: assert property (loss_fault_indication |-> fault_contact && drive_stop)
        else $error("fault without stop or contact");
    fault_hold_a: assert property (loss_fault_indication |=> loss_fault_indication)
        else $error("fault dropped before reset");
    loss_off_a: assert property ((loss_sel == LOSS_OFF) [*3] |-> !loss_warning_indication)
        else $error("warning with detection off");
    forced_freq_a: assert property ((loss_warning_indication && !loss_fault_indication
        && !sleep_active) [*2] |-> freq_ref == $past(forced_freq))
        else $error("forced frequency not driven");
    sleep_zero_a: assert property (sleep_active [*2] |-> freq_ref == 16'h0000)
        else $error("output not zero in sleep");

    cover property ($rose(loss_warning_indication));
    cover property ($rose(loss_fault_indication));
    cover property ($rose(sleep_active));
    cover property ($fell(sleep_active));
endmodule

// file: sim/tb.sv
// Self-checking bench for the process supervisor.
`timescale 1ns/1ns
module tb
    import pps_pkg::*;
;
    logic core_clk = 1'b0, rst = 1'b1, reverse_allow = 1'b0, sleep_di = 1'b0;
    logic sleep_comp = 1'b0, fixed_freq_cmd = 1'b0, rtc_event = 1'b0, neg = 1'b0;
    logic [3:0] ctrl_mode = 4'h1;
    logic [1:0] target_src = 2'h1, feedback_src = 2'h2, loss_sel = 2'h0, sleep_sel = 2'h0;
    logic [1:0] gain_sel = 2'h0;
    logic [PCT_W-1:0] sp = 16'h1388, press = 16'h1388, demand = 16'h1388;
    logic [PCT_W-1:0] target_setting = 16'h1388, target_upper = 16'h1f40;
    logic [PCT_W-1:0] target_lower = 16'h07d0, feedback_gain = PCT_FULL;
    logic [PCT_W-1:0] integral_limit = PCT_FULL, output_limit = PCT_FULL;
    logic [PCT_W-1:0] output_gain = PCT_FULL, loss_level = 16'h03e8, disp_gain = PCT_FULL;
    logic signed [PCT_W-1:0] bias_pct = 16'sh0000, disp_bias = 16'sh0000;
    logic [7:0] filter_shift = 8'h00;
    logic [TIME_W-1:0] target_ramp_time = 12'h0ff, loss_time = 12'h000;
    logic [TIME_W-1:0] sleep_time = 12'h000, wake_time = 12'h000;
    logic [8*DI_COUNT-1:0] di_function = {32'h0000_0000, DI_FN_SET2, DI_FN_RAMP_OFF};
    logic [DI_COUNT-1:0] di_pin = 6'h01;
    logic [FREQ_W-1:0] forced_freq = 16'h0bb8, sleep_freq = 16'h0000, wake_freq = 16'h0800;
    logic [FREQ_W-1:0] freq_cmd = 16'h1388, max_freq = 16'h1770, freq_ref;
    logic [PCT_W-1:0] ain1_pct, ain2_pct, loop_out_pct, loop_integral_pct;
    logic [PCT_W-1:0] loop_target, loop_feedback;
    logic loop_negative, loop_enable, loop_reverse, gain_set_secondary, dir_reverse;
    logic drive_stop, fault_contact, loss_warning_indication, loss_fault_indication;
    logic setting_error_alarm, sleep_active;
    logic signed [PCT_W-1:0] feedback_display;
    int error_cnt = 0, num_checks = 0;

    pps_core i_dut (.*);
    pps_plant i_plant (.*);

    always #25 core_clk = ~core_clk;

    task give_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task reset_dut();
        rst = 1'b1;
        cyc(8);
        rst = 1'b0;
        cyc(4);
    endtask

    task chk_bit(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Waits a bounded number of cycles for a level; running out ends the run.
    task automatic wait_lvl(ref logic s, input logic v);
        for (int i = 0; i < 25000 && s !== v; i++)
            cyc(1);
        chk_bit(s, v, "wait for level");
        if (s !== v)
            give_verdict();
    endtask

    initial begin
        reset_dut();
        chk_bit(loss_fault_indication, 1'b0, "fault after reset");
        for (int m = 0; m < 4; m++) begin
            ctrl_mode = 4'(m);
            cyc(1);
            chk_bit(loop_enable, ctrl_mode[MODE_EN_BIT], "loop enable");
            if (ctrl_mode[MODE_EN_BIT])
                chk_bit(loop_reverse, ctrl_mode[MODE_REV_BIT], "polarity");
        end
        ctrl_mode = 4'h1;
        feedback_src = 2'h1;
        cyc(1);
        chk_bit(setting_error_alarm, 1'b1, "same source alarm");
        chk_bit(loop_enable, 1'b0, "same source loop");
        feedback_src = 2'h2;
        cyc(1);
        chk_bit(setting_error_alarm, 1'b0, "alarm clears");
        chk_val(loop_feedback, 16'h1388, "unity feedback gain");
        chk_val(feedback_display, 16'h1388, "display scaling");
        feedback_gain = 16'h4e20;
        cyc(1);
        chk_val(loop_feedback, 16'h2710, "double feedback gain");
        feedback_gain = PCT_FULL;
        sp = 16'h2328;
        cyc(5);
        chk_val(loop_target, target_upper, "upper target clamp");
        sp = 16'h03e8;
        cyc(5);
        chk_val(loop_target, target_lower, "lower target clamp");
        for (int g = 0; g < 8; g++) begin
            gain_sel = 2'(g);
            di_pin[1] = g[2];
            rtc_event = g[2];
            cyc(4);
            chk_bit(gain_set_secondary, g == 1 || g >= 5, "gain set");
        end
        gain_sel = GSEL_PRI;
        press = 16'h0100;
        cyc(6);
        chk_bit(loss_warning_indication, 1'b0, "detection off");
        loss_sel = LOSS_WARN;
        wait_lvl(loss_warning_indication, 1'b1);
        cyc(2);
        chk_val(freq_ref, forced_freq, "forced frequency");
        chk_bit(drive_stop, 1'b0, "warning keeps running");
        press = 16'h1388;
        wait_lvl(loss_warning_indication, 1'b0);
        loss_sel = LOSS_FAULT;
        press = 16'h0100;
        wait_lvl(loss_fault_indication, 1'b1);
        cyc(1);
        chk_bit(fault_contact, 1'b1, "fault contact");
        chk_bit(drive_stop, 1'b1, "fault stops drive");
        press = 16'h1388;
        cyc(6);
        chk_bit(loss_fault_indication, 1'b1, "fault latched");
        loss_sel = LOSS_OFF;
        reset_dut();
        chk_bit(loss_fault_indication, 1'b0, "fault cleared");
        neg = 1'b1;
        cyc(2);
        chk_bit(dir_reverse, 1'b0, "reverse refused");
        reverse_allow = 1'b1;
        cyc(1);
        chk_bit(dir_reverse, 1'b1, "reverse permitted");
        neg = 1'b0;
        reverse_allow = 1'b0;
        demand = 16'h0100;
        sleep_freq = 16'h0fa0;
        sleep_sel = SLP_TIMED;
        wait_lvl(sleep_active, 1'b1);
        cyc(2);
        chk_val(freq_ref, 16'h0000, "sleep output");
        sleep_freq = 16'h0000;
        demand = 16'h2000;
        output_limit = 16'h1388;
        wait_lvl(sleep_active, 1'b0);
        cyc(2);
        chk_val(freq_ref, 16'h0bb8, "limited output");
        sleep_sel = SLP_DI;
        sleep_di = 1'b1;
        wait_lvl(sleep_active, 1'b1);
        give_verdict();
    end
endmodule

bind pps_core pps_core_props i_props (.*);
